// ===== rtl/scpc_pkg.sv
// Shared constants and types for the system clock prescaler control block
package scpc_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_PRESCALE = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_TIMER_ASYNC = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h0F;
    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int CHANGE_ENABLE_BIT = 7;
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
    localparam logic [3:0] DIV_RESET_BY8 = 4'h3;
    localparam logic [3:0] DIV_MAX_CODE = 4'h8;
    localparam logic [3:0] CLKSRC_EXTERNAL = 4'h0;
    localparam logic [3:0] CLKSRC_RC_8M = 4'h2;
    localparam logic [3:0] CLKSRC_RC_128K = 4'h3;
    localparam int TIMER_EXT_CLK_BIT = 6;
    localparam logic [1:0] SUT_SHORT = 2'h0;
    localparam logic [1:0] SUT_MEDIUM = 2'h1;
    localparam logic [1:0] SUT_LONG = 2'h2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 10000;
    localparam int WINDOW_CYCLES = 4;
    localparam int WAKE_CYCLES = 6;
    localparam int RESET_BASE_CYCLES = 14;
    localparam int SHORT_DELAY_US10 = 41;
    localparam int LONG_DELAY_US10 = 650;
    // Delays kept in tenths of a millisecond; divide first so the product stays in range
    localparam int TENTH_MS_PS = 100000000;
    localparam int SHORT_DELAY_CYC = SHORT_DELAY_US10 * (TENTH_MS_PS / CLK_PERIOD_PS);
    localparam int LONG_DELAY_CYC = LONG_DELAY_US10 * (TENTH_MS_PS / CLK_PERIOD_PS);
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {ST_RESET_WAIT, ST_RUN, ST_WAKE_WAIT} scpc_start_e;
    typedef struct packed {
        logic [3:0] clk_source;
        logic [1:0] startup_time;
        logic divide_by_eight;
        logic clock_output;
    } scpc_fuses_s;
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } scpc_ahb_req_s;
endpackage : scpc_pkg

// ===== rtl/scpc_ripple_div.sv
// Glitch-free power-of-two divider that follows the selected division code
`timescale 1ns/1ps
module scpc_ripple_div #(
    parameter int DIV_W = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [DIV_W-1:0] i_code,
    output logic o_tick,
    output logic o_clk_div
);
    logic [8:0] cnt_q;
    logic [DIV_W-1:0] cur_code_q;
    logic [8:0] half_mask;
    logic [8:0] full_mask;
    logic wrap;

    // Division factor is two raised to the code; code 0 passes every edge
    assign full_mask = 9'(({9'h001} << cur_code_q) - 9'h001);
    assign half_mask = 9'({9'h001} << cur_code_q) >> 1;
    assign wrap = ((cnt_q & full_mask) == full_mask);
    assign o_tick = wrap;

    // ****************************************
    // Counter
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_q <= 9'h000;
        else if (wrap)
            cnt_q <= 9'h000;
        else
            cnt_q <= 9'(cnt_q + 9'h001);
    end

    // New code only at a period boundary: no short pulse can appear
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cur_code_q <= '0;
        else if (wrap)
            cur_code_q <= i_code;
    end

    // Divided clock as a registered level (high in first half of period)
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_clk_div <= 1'b0;
        else if (wrap)
            o_clk_div <= 1'b1;
        else if (cur_code_q != '0 && ((cnt_q + 9'h001) & half_mask) != 9'h000
                 && (((cnt_q + 9'h001) & (half_mask - 9'h001)) == 9'h000))
            o_clk_div <= 1'b0;
    end
endmodule : scpc_ripple_div

// ===== rtl/scpc_top.sv
// System clock prescaler control with AHB-Lite register access
`timescale 1ns/1ps
// ****************************************
// ****************************************
module scpc_top #(
    parameter int SHORT_DELAY = scpc_pkg::SHORT_DELAY_CYC,
    parameter int LONG_DELAY = scpc_pkg::LONG_DELAY_CYC
) (
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic I_HSEL,
    input wire logic I_HREADY,
    input wire logic [31:0] I_HWDATA,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire scpc_pkg::scpc_fuses_s I_FUSES,
    input wire logic I_WAKE_REQ,
    input wire logic I_PORT_OUT,
    output logic O_CLOCK_OUTPUT_PIN,
    output logic O_SYS_CLK_EN,
    output logic O_SYS_CLK,
    output logic O_CORE_RUN,
    output logic O_EXT_CLK_SELECTED,
    output logic O_TIMER_OSC_EN,
    output logic O_TIMER_EXT_CLK
);
    // ****************************************
    // Bus slave
    // ****************************************
    logic ph_valid_q;
    logic ph_write_q;
    logic [7:0] ph_addr_q;
    logic addr_ok;
    logic wr_prescale;
    logic [7:0] wdata;
    logic [3:0] div_q;
    logic ce_q;
    logic [2:0] ce_cnt_q;
    logic timer_ext_q;
    logic timer_osc_req_q;
    logic tick;
    logic clk_div;
    scpc_pkg::scpc_start_e st_q;
    logic [31:0] wait_q;
    logic [31:0] reset_delay;
    logic is_rc;

    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign addr_ok = I_HSEL && I_HREADY && I_HTRANS[1];
    assign wdata = I_HWDATA[7:0];
    assign wr_prescale = ph_valid_q && ph_write_q && ph_addr_q == scpc_pkg::ADDR_PRESCALE;

    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end
        else
        begin
            ph_valid_q <= addr_ok;
            ph_write_q <= I_HWRITE;
            ph_addr_q <= I_HADDR[7:0];
        end
    end

    // Read data registered at the address phase; one-cycle data phase
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            O_HRDATA <= 32'h0000_0000;
        else if (addr_ok && !I_HWRITE)
        begin
            unique case (I_HADDR[7:0])
                scpc_pkg::ADDR_PRESCALE: O_HRDATA <= {24'h000000, ce_q, 3'h0, div_q};
                scpc_pkg::ADDR_CONFIG:
                    O_HRDATA <= {24'h000000, I_FUSES};
                scpc_pkg::ADDR_TIMER_ASYNC:
                    O_HRDATA <= {24'h000000, timer_osc_req_q, timer_ext_q, 6'h00};
                scpc_pkg::ADDR_STATUS:
                    O_HRDATA <= {28'h0000000, O_TIMER_OSC_EN, O_EXT_CLK_SELECTED,
                                 O_CORE_RUN, ce_q};
                default: O_HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Prescale register
    // ****************************************
    // Enable bit and its window; set only from a write with other bits zero
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ce_q <= 1'b0;
            ce_cnt_q <= 3'h0;
        end
        else if (wr_prescale && wdata[scpc_pkg::CHANGE_ENABLE_BIT] && wdata[6:0] == 7'h00)
        begin
            if (!ce_q)
            begin
                ce_q <= 1'b1;
                ce_cnt_q <= 3'h0;
            end
            else if (tick)
            begin
                ce_cnt_q <= 3'(ce_cnt_q + 3'h1);
                if (ce_cnt_q == 3'(scpc_pkg::WINDOW_CYCLES - 1))
                    ce_q <= 1'b0;
            end
        end
        else if (ce_q && wr_prescale && !wdata[scpc_pkg::CHANGE_ENABLE_BIT])
            ce_q <= 1'b0;
        else if (ce_q && tick)
        begin
            ce_cnt_q <= 3'(ce_cnt_q + 3'h1);
            if (ce_cnt_q == 3'(scpc_pkg::WINDOW_CYCLES - 1))
                ce_q <= 1'b0;
        end
    end

    // Division code; reset value caught after release from the fuse
    logic div_loaded_q;
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            div_q <= scpc_pkg::DIV_RESET_PLAIN;
            div_loaded_q <= 1'b0;
        end
        else if (!div_loaded_q)
        begin
            div_loaded_q <= 1'b1;
            div_q <= I_FUSES.divide_by_eight ? scpc_pkg::DIV_RESET_BY8
                                             : scpc_pkg::DIV_RESET_PLAIN;
        end
        else if (wr_prescale && ce_q && !wdata[scpc_pkg::CHANGE_ENABLE_BIT]
                 && wdata[3:0] <= scpc_pkg::DIV_MAX_CODE)
            div_q <= wdata[3:0];
    end

    // ****************************************
    // Divider
    // ****************************************
    // Reserved codes are refused above, so the factor stays a power of two
    scpc_ripple_div #(
        .DIV_W(scpc_pkg::DIV_W)
    ) u_div (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .i_code(div_q),
        .o_tick(tick),
        .o_clk_div(clk_div)
    );

    // One enable feeds CPU, flash, I/O and converter clock gates alike
    assign O_SYS_CLK_EN = tick && O_CORE_RUN;
    assign O_SYS_CLK = clk_div;

    // Clock pin forced by the fuse even while held in reset
    assign O_CLOCK_OUTPUT_PIN = I_FUSES.clock_output ? (I_RST_B ? clk_div : I_MCLK)
                                                    : I_PORT_OUT;

    // ****************************************
    // Clock source and start-up
    // ****************************************
    assign O_EXT_CLK_SELECTED = I_FUSES.clk_source == scpc_pkg::CLKSRC_EXTERNAL;
    assign is_rc = I_FUSES.clk_source == scpc_pkg::CLKSRC_RC_8M
                   || I_FUSES.clk_source == scpc_pkg::CLKSRC_RC_128K;
    assign O_TIMER_OSC_EN = timer_osc_req_q && is_rc;
    assign O_TIMER_EXT_CLK = O_TIMER_OSC_EN && timer_ext_q;

    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            timer_ext_q <= 1'b0;
            timer_osc_req_q <= 1'b0;
        end
        else if (ph_valid_q && ph_write_q && ph_addr_q == scpc_pkg::ADDR_TIMER_ASYNC)
        begin
            timer_ext_q <= wdata[scpc_pkg::TIMER_EXT_CLK_BIT];
            timer_osc_req_q <= wdata[scpc_pkg::TIMER_EXT_CLK_BIT + 1];
        end
    end

    always_comb
    begin
        unique case (I_FUSES.startup_time)
            scpc_pkg::SUT_SHORT: reset_delay = 32'(scpc_pkg::RESET_BASE_CYCLES);
            scpc_pkg::SUT_MEDIUM: reset_delay = 32'(scpc_pkg::RESET_BASE_CYCLES + SHORT_DELAY);
            scpc_pkg::SUT_LONG: reset_delay = 32'(scpc_pkg::RESET_BASE_CYCLES + LONG_DELAY);
            default: reset_delay = 32'(scpc_pkg::RESET_BASE_CYCLES + LONG_DELAY);
        endcase
    end

    // Reserved start-up code takes the longest wait, the safe side
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st_q <= scpc_pkg::ST_RESET_WAIT;
            wait_q <= 32'h0000_0000;
        end
        else
        begin
            unique case (st_q)
                scpc_pkg::ST_RESET_WAIT:
                    if (wait_q + 32'h1 >= reset_delay)
                    begin
                        st_q <= scpc_pkg::ST_RUN;
                        wait_q <= 32'h0000_0000;
                    end
                    else
                        wait_q <= wait_q + 32'h1;
                scpc_pkg::ST_RUN:
                    if (I_WAKE_REQ)
                        st_q <= scpc_pkg::ST_WAKE_WAIT;
                scpc_pkg::ST_WAKE_WAIT:
                    if (wait_q + 32'h1 >= 32'(scpc_pkg::WAKE_CYCLES))
                    begin
                        st_q <= scpc_pkg::ST_RUN;
                        wait_q <= 32'h0000_0000;
                    end
                    else
                        wait_q <= wait_q + 32'h1;
            endcase
        end
    end

    assign O_CORE_RUN = st_q == scpc_pkg::ST_RUN;
endmodule : scpc_top

// ===== verification/scpc_assertions.sv
// Port-level concurrent checks for the system clock prescaler control block
`timescale 1ns/1ps
module scpc_assertions (
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic I_HSEL,
    input wire logic I_HREADY,
    input wire logic [31:0] I_HWDATA,
    input wire logic [31:0] O_HRDATA,
    input wire scpc_pkg::scpc_fuses_s I_FUSES,
    input wire logic I_PORT_OUT,
    input wire logic O_CLOCK_OUTPUT_PIN,
    input wire logic O_SYS_CLK_EN,
    input wire logic O_SYS_CLK,
    input wire logic O_CORE_RUN,
    input wire logic O_EXT_CLK_SELECTED,
    input wire logic O_TIMER_OSC_EN,
    input wire logic O_TIMER_EXT_CLK
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic [4:0] age_q;
    // ****************************************
    // Data phase tracking
    // ****************************************
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_q <= I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
            rd_q <= I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;
            addr_q <= I_HADDR[7:0];
        end
    end
    // Saturates so the start-up bound never wraps
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            age_q <= 5'h00;
        else if (age_q != 5'h1F)
            age_q <= age_q + 5'h01;
    end
    sequence async_wr_s;
        wr_q && addr_q == scpc_pkg::ADDR_TIMER_ASYNC;
    endsequence
    ext_select_a: assert property (
        O_EXT_CLK_SELECTED == (I_FUSES.clk_source == scpc_pkg::CLKSRC_EXTERNAL))
        else $error("external select mismatch");
    start_delay_a: assert property (O_CORE_RUN |-> age_q >= 5'h0E)
        else $error("core started too early");
    clock_pin_a: assert property (I_FUSES.clock_output |-> O_CLOCK_OUTPUT_PIN == O_SYS_CLK)
        else $error("pin not the divided clock");
    port_pin_a: assert property (!I_FUSES.clock_output |-> O_CLOCK_OUTPUT_PIN == I_PORT_OUT)
        else $error("pin not the port value");
    timer_osc_a: assert property (O_TIMER_OSC_EN |-> I_FUSES.clk_source inside {4'h2, 4'h3})
        else $error("timer oscillator without RC source");
    timer_ext_a: assert property (async_wr_s |=>
        O_TIMER_EXT_CLK == ($past(I_HWDATA[6]) && O_TIMER_OSC_EN))
        else $error("timer clock select not taken");
    clk_rise_a: assert property (
        $rose(O_SYS_CLK) && $past(O_CORE_RUN) |-> $past(O_SYS_CLK_EN))
        else $error("divided clock rose off a period boundary");
    en_gate_a: assert property (O_SYS_CLK_EN |-> O_CORE_RUN)
        else $error("clock enable before start-up");
    read_hold_a: assert property (!rd_q |-> $stable(O_HRDATA))
        else $error("read data moved without a read");
endmodule : scpc_assertions

// ===== verification/scpc_sw_model.sv
// Software side model: single-word AHB-Lite master that programs the prescaler
`timescale 1ns/1ps
module scpc_sw_model (
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output scpc_pkg::scpc_ahb_req_s o_req,
    output logic [31:0] o_hwdata
);
    initial
    begin
        o_req = '0;
        o_hwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        @(posedge i_clk);
        o_req <= '{haddr: {24'h0, addr}, htrans: 2'h2, hwrite: wr, hsize: 3'h2, hsel: 1'b1};
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_req.htrans <= 2'h0;
        o_req.hsel <= 1'b0;
        o_hwdata <= wdata;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        rdata = i_hrdata;
        // Released data lines must not keep the old value
        o_hwdata <= ~wdata;
    endtask : xfer
    task automatic unlock(input logic [3:0] code);
        logic [31:0] d;
        xfer(1'b1, scpc_pkg::ADDR_PRESCALE, 32'h80, d);
        xfer(1'b1, scpc_pkg::ADDR_PRESCALE, {28'h0, code}, d);
    endtask : unlock
endmodule : scpc_sw_model

// ===== verification/test_system_clock_prescaler_ctrl.sv
// Self-checking testbench for the system clock prescaler control block
`timescale 1ns/1ps
module test_system_clock_prescaler_ctrl;
    logic clk;
    logic rst_b;
    scpc_pkg::scpc_fuses_s fuses;
    logic port_out;
    scpc_pkg::scpc_ahb_req_s req;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic wake;
    logic pin;
    logic sys_en;
    logic core_run;
    logic ext_sel;
    logic osc_en;
    logic tmr_ext;
    logic [31:0] rd;
    int num_errors = 0;
    int n_tests = 0;
    scpc_top #(.SHORT_DELAY(20), .LONG_DELAY(40)) dut_u (.I_MCLK(clk), .I_RST_B(rst_b),
        .I_HADDR(req.haddr), .I_HTRANS(req.htrans), .I_HWRITE(req.hwrite), .I_HSIZE(req.hsize),
        .I_HSEL(req.hsel), .I_HREADY(hready), .I_HWDATA(hwdata), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_FUSES(fuses), .I_WAKE_REQ(wake),
        .I_PORT_OUT(port_out), .O_CLOCK_OUTPUT_PIN(pin), .O_SYS_CLK_EN(sys_en), .O_SYS_CLK(),
        .O_CORE_RUN(core_run), .O_EXT_CLK_SELECTED(ext_sel), .O_TIMER_OSC_EN(osc_en),
        .O_TIMER_EXT_CLK(tmr_ext));
    scpc_sw_model sw_u (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_req(req),
        .o_hwdata(hwdata));
    // Steady source, never varies cycle to cycle
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        sw_u.xfer(1'b0, addr, 32'h0, rd);
        check(rd, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        sw_u.xfer(1'b1, addr, data, rd);
    endtask : wr
    task automatic period(input int exp);
        int n;
        int k;
        k = 0;
        for (n = 0; k < 3 && n < 4000; n++)
        begin
            @(posedge clk);
            if (sys_en === 1'b1)
                k++;
        end
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (sys_en !== 1'b1 && n < 600);
        check(32'(n), 32'(exp));
    endtask : period
    task automatic t_startup;
        int n;
        for (n = 0; core_run !== 1'b1 && n < 100; n++)
            @(posedge clk);
        check(32'(n >= 34 && n <= 36), 32'h1);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h03);
        rd_chk(scpc_pkg::ADDR_STATUS, 32'h06);
        period(8);
    endtask : t_startup
    task automatic t_wake;
        int n;
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        check({31'h0, core_run}, 32'h0);
        for (n = 0; core_run !== 1'b1 && n < 20; n++)
        begin
            @(posedge clk);
            #1;
        end
        check(32'(n), 32'(scpc_pkg::WAKE_CYCLES));
    endtask : t_wake
    task automatic t_rereset;
        int n;
        @(posedge clk);
        rst_b <= 1'b0;
        fuses.divide_by_eight <= 1'b0;
        fuses.clock_output <= 1'b1;
        @(posedge clk);
        #1;
        check({31'h0, pin}, 32'h1);
        #5;
        check({31'h0, pin}, 32'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        for (n = 0; core_run !== 1'b1 && n < 100; n++)
            @(posedge clk);
        check(32'(n >= 34 && n <= 36), 32'h1);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h00);
        period(1);
    endtask : t_rereset
    task automatic t_codes;
        for (int c = 0; c <= 8; c++)
        begin
            sw_u.unlock(4'(c));
            rd_chk(scpc_pkg::ADDR_PRESCALE, 32'(c));
            period(1 << c);
        end
        // Reserved code must leave the division alone
        sw_u.unlock(4'h9);
        sw_u.xfer(1'b0, scpc_pkg::ADDR_PRESCALE, 32'h0, rd);
        check(rd & 32'hF, 32'h8);
        sw_u.unlock(4'h4);
        period(16);
    endtask : t_codes
    task automatic t_window;
        wr(scpc_pkg::ADDR_PRESCALE, 32'h80);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h84);
        repeat (40) @(posedge clk);
        wr(scpc_pkg::ADDR_PRESCALE, 32'h80);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h84);
        repeat (40) @(posedge clk);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h04);
        wr(scpc_pkg::ADDR_PRESCALE, 32'h03);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h04);
        wr(scpc_pkg::ADDR_PRESCALE, 32'h81);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h04);
        wr(scpc_pkg::ADDR_PRESCALE, 32'h02);
        rd_chk(scpc_pkg::ADDR_PRESCALE, 32'h04);
    endtask : t_window
    task automatic t_pins;
        rd_chk(8'h10, 32'h0);
        check({31'h0, hresp}, 32'h0);
        @(posedge clk);
        fuses.clock_output <= 1'b0;
        fuses.clk_source <= scpc_pkg::CLKSRC_RC_8M;
        port_out <= 1'b1;
        wr(scpc_pkg::ADDR_TIMER_ASYNC, 32'hC0);
        #1;
        check({pin, ext_sel, osc_en, tmr_ext}, 32'hB);
        @(posedge clk);
        fuses.clk_source <= scpc_pkg::CLKSRC_EXTERNAL;
        port_out <= 1'b0;
        wr(scpc_pkg::ADDR_TIMER_ASYNC, 32'h80);
        #1;
        check({pin, ext_sel, osc_en, tmr_ext}, 32'h4);
    endtask : t_pins
    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial
    begin
        rst_b = 1'b0;
        port_out = 1'b0;
        wake = 1'b0;
        // Medium start-up code, 14 plus the short delay; divide by eight keeps the rate legal
        fuses = '{clk_source: 4'h0, startup_time: 2'h1, divide_by_eight: 1'b1, clock_output: 1'b1};
        repeat (15) @(posedge clk);
        #1;
        check({31'h0, pin}, 32'h1);
        @(posedge clk);
        rst_b <= 1'b1;
        t_startup();
        t_wake();
        t_codes();
        t_window();
        t_pins();
        t_rereset();
        complete_run();
    end
    initial
    begin
        #600000;
        num_errors++;
        complete_run();
    end
endmodule : test_system_clock_prescaler_ctrl
bind scpc_top scpc_assertions chk_u (.I_MCLK, .I_RST_B, .I_HADDR, .I_HTRANS, .I_HWRITE,
    .I_HSEL, .I_HREADY, .I_HWDATA, .O_HRDATA, .I_FUSES, .I_PORT_OUT, .O_CLOCK_OUTPUT_PIN,
    .O_SYS_CLK_EN, .O_SYS_CLK, .O_CORE_RUN, .O_EXT_CLK_SELECTED, .O_TIMER_OSC_EN,
    .O_TIMER_EXT_CLK);
